// ==== dv/dor_router_tb.sv ====
// Self-checking bench for the display output router
`timescale 1ns/1ns
`include "dor_params.svh"
module dor_router_tb;
   typedef struct packed {
      logic [3:0] k;
      logic [3:0] i;
      logic [31:0] v;
   } dor_note_t;
   logic mclk, rstn, pipe_join, te_util_pin, second_tear_input_pin, utility_pin_control;
   dor_pkg::dor_plane_t [`DOR_NPIPE-1:0][`DOR_LAYERS-1:0] plane_in;
   dor_pkg::dor_pix_t [`DOR_NPIPE-1:0] bg_color, blend_pix;
   logic [`DOR_NPIPE-1:0][`DOR_NSCL-1:0][2:0] scl_sel, scl_tgt;
   dor_pkg::dor_preq_t [`DOR_NPIPE-1:0] pipe_req, pipe_route;
   dor_pkg::dor_treq_t [`DOR_NTR-1:0] trans_req, trans_route;
   logic [`DOR_NPORT-1:0] port_mst;
   dor_pkg::dor_lane_t [1:0][`DOR_NLANE-1:0] cb_in, cb_pin;
   dor_pkg::dor_lane_t [1:0][4:0] dsi_in;
   dor_pkg::dor_lane_t [1:0] cb_aux;
   logic [1:0] cb_rev, cb_tmds, cb_dsi_strap, te_out, hp_port;
   dor_pkg::dor_lane_t [`DOR_NTC-1:0][`DOR_NLANE-1:0] tc_in, tc_pin;
   dor_pkg::dor_tcm_t [`DOR_NTC-1:0] tc_mode;
   logic [`DOR_NTC-1:0] tc_shared, tc_lanes4, hp_evt, hp_prev;
   logic [`DOR_NTC-1:0][2:0] hp_pin;
   dor_pkg::dor_hp_t [`DOR_NTC-1:0] hp_path;
   logic [`DOR_NWB-1:0] wb_active;
   logic route_err, fire;
   logic [2:0] hp_mask;
   logic [3:0] h;
   logic [3:0] hq[$];
   dor_note_t q[$];
   dor_note_t n;
   dor_pkg::dor_pix_t e;
   int num_errors = 0, comparisons = 0;
   int dm[4] = '{1, 2, 4, 3};
   logic [2:0] hm[6] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5};

   dor_router dut (.mclk, .rstn, .plane_in, .bg_color, .scl_sel, .pipe_req, .pipe_join,
      .trans_req, .port_mst, .cb_in, .dsi_in, .cb_rev, .cb_tmds, .cb_dsi_strap, .tc_in,
      .tc_mode, .tc_shared, .hp_pin, .te_util_pin, .second_tear_input_pin,
      .utility_pin_control, .blend_pix, .scl_tgt, .pipe_route, .trans_route, .route_err,
      .cb_pin, .cb_aux, .tc_pin, .tc_lanes4, .hp_evt, .hp_path, .te_out, .wb_active);
   dor_tcmux_model part (.mclk, .fire, .port(hp_port), .mask(hp_mask), .hp_pin);

   task automatic print_verdict();
      if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp_val(input dor_note_t m, input logic [31:0] g);
      comparisons++;
      if (g !== m.v) begin
         num_errors++;
         $display("unexpected at %0t: kind %0d idx %0d exp %h got %h", $time, m.k, m.i, m.v, g);
      end
   endtask
   task automatic cmp_hp(input logic [3:0] x, input logic [3:0] g);
      comparisons++;
      if (g !== x) begin
         num_errors++;
         $display("unexpected at %0t: hotplug exp %h got %h", $time, x, g);
      end
   endtask
   function automatic logic [31:0] got(input dor_note_t m);
      case (m.k)
         4'h0: return 32'(blend_pix[m.i]);
         4'h1: return 32'(pipe_route[m.i]);
         4'h2: return 32'(trans_route[m.i]);
         4'h3: return 32'(route_err);
         4'h4: return 32'(cb_pin[m.i[2]][m.i[1:0]]);
         4'h5: return 32'(cb_aux[m.i[0]]);
         4'h6: return 32'(tc_pin[m.i[3:2]][m.i[1:0]]);
         4'h7: return 32'(tc_lanes4[m.i]);
         4'h8: return 32'(wb_active[m.i]);
         4'h9: return 32'(te_out[m.i]);
         default: return 32'(scl_tgt[m.i[2:1]][m.i[0]]);
      endcase
   endfunction
   task automatic note(input int k, input int i, input logic [31:0] v);
      q.push_back({4'(k), 4'(i), v});
   endtask
   // Inputs move only at falling edges, except hp_pin, which the model moves 3ns after a rising edge; one rising edge per step
   task automatic step(input int c = 1);
      repeat (c) @(negedge mclk);
   endtask
   task automatic clr();
      pipe_req = '0;
      trans_req = '0;
      port_mst = '0;
      pipe_join = 1'b0;
   endtask
   // f is {dsc, aud, ssr}; barred bits are dropped, not refused; pg 2 skips the pipe check
   task automatic route(input int p, tr, t, pt, f, pg, tg);
      clr();
      pipe_req[p] = {1'b1, 3'(tr)};
      trans_req[t] = {1'b1, 3'(pt), 3'(f)};
      if (pg < 2) note(1, p, pg ? {28'h0, 1'b1, 3'(tr)} : 32'h0);
      note(2, t, tg ? {25'h0, 1'b1, 3'(pt), f[2] && t != 0 && t < 6, f[1] && t < 3,
         f[0] && t == 3} : 32'h0);
      note(3, 0, 32'(!tg));
      if (t > 5) note(8, t - 6, 32'(tg));
      step();
   endtask

   always @(posedge mclk) begin
      #1;
      while (q.size() > 0) begin
         n = q.pop_front();
         cmp_val(n, got(n));
      end
      for (int i = 0; i < `DOR_NTC; i++) begin
         if (hp_evt[i] === 1'b1) begin
            h = hq.size() > 0 ? hq.pop_front() : 4'hf;
            cmp_hp(hp_prev[i] === 1'b1 ? 4'hf : h, {i[1:0], hp_path[i]});
         end
      end
      hp_prev = hp_evt;
   end
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      num_errors++;
      print_verdict();
   end
   initial begin
      rstn = 1'b0;
      clr();
      plane_in = '0;
      bg_color = '0;
      scl_sel = '0;
      cb_in = '0;
      dsi_in = '0;
      cb_rev = 2'h0;
      cb_tmds = 2'h0;
      cb_dsi_strap = 2'h2;
      tc_in = '0;
      tc_mode = '0;
      tc_shared = '0;
      te_util_pin = 1'b0;
      second_tear_input_pin = 1'b0;
      utility_pin_control = 1'b0;
      fire = 1'b0;
      hp_port = 2'h0;
      hp_mask = 3'h0;
      hp_prev = '0;
      void'($urandom(997));
      repeat (12) @(posedge mclk);
      step();
      rstn = 1'b1;
      step(2);
      for (int it = 0; it < 6; it++) begin
         for (int p = 0; p < 3; p++) begin
            bg_color[p] = 30'($urandom);
            e = bg_color[p];
            for (int l = 0; l < 8; l++) begin
               plane_in[p][l] = {it > 0 && $urandom_range(1, 0) == 1, 30'($urandom)};
               if (plane_in[p][l].vis) e = plane_in[p][l].pix;
            end
            note(0, p, 32'(e));
            for (int s = 0; s < 2; s++) begin
               scl_sel[p][s] = 3'($urandom);
               note(10, p * 2 + s, 32'(scl_sel[p][s]));
            end
         end
         step();
      end
      route(0, 0, 0, 2, 0, 1, 1);
      route(0, 0, 0, 0, 0, 2, 0);
      route(0, 0, 0, 1, 0, 2, 0);
      route(0, 1, 1, 3, 0, 0, 0);
      route(1, 3, 3, 0, 1, 1, 1);
      route(1, 3, 3, 1, 0, 2, 0);
      route(1, 3, 3, 0, 2, 1, 1);
      route(2, 2, 2, 5, 1, 1, 1);
      route(0, 0, 0, 3, 4, 1, 1);
      route(2, 2, 2, 4, 4, 1, 1);
      route(0, 4, 4, 0, 0, 2, 0);
      route(2, 6, 6, 6, 0, 1, 1);
      route(0, 7, 7, 2, 0, 2, 0);
      for (int m = 0; m < 4; m++) begin
         clr();
         pipe_req[m / 2] = {1'b1, m > 1 ? 3'h3 : 3'h0};
         pipe_req[m / 2 + 1] = {1'b1, m > 1 ? 3'h3 : 3'h1};
         trans_req[0] = {1'(m < 2), 3'h2, 3'h0};
         trans_req[1] = {1'(m < 2), 3'h2, 3'h0};
         trans_req[3] = {1'(m > 1), 3'h0, 3'h0};
         port_mst[2] = m == 1;
         pipe_join = m == 3;
         if (m < 2) note(2, 1, m == 1 ? {25'h0, 1'b1, 3'h2, 3'h0} : 32'h0);
         if (m > 1) note(1, 2, m == 3 ? {28'h0, 1'b1, 3'h3} : 32'h0);
         note(3, 0, 32'(m == 0 || m == 2));
         step();
      end
      route(1, 5, 5, 1, 0, 1, 1);
      te_util_pin = 1'b1;
      utility_pin_control = 1'b1;
      second_tear_input_pin = 1'b1;
      step(4);
      note(9, 1, 32'h1);
      note(9, 0, 32'h0);
      step();
      second_tear_input_pin = 1'b0;
      step(4);
      note(9, 1, 32'h0);
      step();
      // Strap changes after lock must not move either port's mode
      cb_dsi_strap = 2'h1;
      for (int s = 0; s < 4; s++) begin
         cb_rev = {s[1], s[0]};
         cb_tmds = {s[0], s[1]};
         cb_in = 80'({$urandom, $urandom, $urandom});
         dsi_in = 100'({$urandom, $urandom, $urandom, $urandom});
         for (int k = 0; k < 4; k++) begin
            note(4, k, 32'(cb_in[0][(s[0] ^ s[1]) ? 3 - k : k]));
            note(4, 4 + k, 32'(dsi_in[1][dm[k]]));
         end
         note(5, 1, 32'(dsi_in[1][0]));
         step();
      end
      for (int s = 0; s < 6; s++) begin
         tc_in = 160'({$urandom, $urandom, $urandom, $urandom, $urandom});
         for (int c = 0; c < 4; c++) begin
            tc_mode[c] = dor_pkg::dor_tcm_t'(1 + (s + c) % 3);
            tc_shared[c] = 1'($urandom);
            if (tc_mode[c] == dor_pkg::TCM_ALT) note(7, c, 32'(!tc_shared[c]));
            for (int k = 0; k < 4; k++) begin
               if (tc_mode[c] != dor_pkg::TCM_ALT)
                  note(6, c * 4 + k, tc_mode[c] == dor_pkg::TCM_LEG ? 32'(tc_in[c][k]) : 32'h0);
            end
         end
         step();
      end
      for (int s = 0; s < 6; s++) begin
         hp_port = 2'(s);
         hp_mask = hm[s];
         hq.push_back({2'(s), hm[s][0] ? 2'h1 : hm[s][1] ? 2'h2 : 2'h3});
         fire = 1'b1;
         step();
         fire = 1'b0;
         step(12);
         tc_mode[2'(s)] = dor_pkg::dor_tcm_t'(hm[s][0] ? 2'h3 : hm[s][1] ? 2'h2 : 2'h1);
      end
      cmp_hp(4'h0, 4'(hq.size()));
      print_verdict();
   end
endmodule

// ==== dv/dor_tcmux_model.sv ====
// Type C sub-system side model: raises hotplug pins on request
`timescale 1ns/1ns
module dor_tcmux_model (
   input wire logic mclk,
   input wire logic fire,
   input wire logic [1:0] port,
   input wire logic [2:0] mask,
   output logic [3:0][2:0] hp_pin
);
   logic [1:0] p;
   initial hp_pin = '0;
   // Pins move off the clock edge: the real source has no relation to mclk
   always @(posedge mclk) begin
      if (fire) begin
         p = port;
         #3 hp_pin[p] = mask;
         repeat (6) @(posedge mclk);
         #3 hp_pin[p] = 3'h0;
      end
   end
endmodule

// ==== verilog/dor_params.svh ====
// Constants for the display output router
`ifndef DOR_PARAMS_SVH
`define DOR_PARAMS_SVH
`define DOR_PIX_W 30
`define DOR_LANE_W 10
`define DOR_NPIPE 3
`define DOR_NTR 8
`define DOR_NPORT 6
`define DOR_NTC 4
`define DOR_LAYERS 8
`define DOR_NSCL 2
`define DOR_NLANE 4
`define DOR_SHR_LANES 2
`define DOR_NWB 2
`endif

// ==== verilog/dor_pkg.sv ====
// Types shared by the display output router
`include "dor_params.svh"
package dor_pkg;
   typedef logic [`DOR_LANE_W-1:0] dor_lane_t;
   typedef logic [`DOR_PIX_W-1:0] dor_pix_t;
   typedef enum logic [2:0] {
      TR_A = 3'b000, TR_B = 3'b001, TR_C = 3'b010, TR_EDP = 3'b011,
      TR_DSI0 = 3'b100, TR_DSI1 = 3'b101, TR_WD0 = 3'b110, TR_WD1 = 3'b111
   } dor_trans_t;
   typedef enum logic [2:0] {
      PT_A = 3'b000, PT_B = 3'b001, PT_C = 3'b010, PT_D = 3'b011,
      PT_E = 3'b100, PT_F = 3'b101, PT_MEM = 3'b110, PT_NONE = 3'b111
   } dor_port_t;
   typedef enum logic [1:0] {
      TCM_OFF = 2'b00, TCM_ALT = 2'b01, TCM_TUN = 2'b10, TCM_LEG = 2'b11
   } dor_tcm_t;
   typedef enum logic [1:0] {
      HP_NONE = 2'b00, HP_LEG = 2'b01, HP_TUN = 2'b10, HP_ALT = 2'b11
   } dor_hp_t;
   typedef struct packed {
      logic vis;
      dor_pix_t pix;
   } dor_plane_t;
   typedef struct packed {
      logic en;
      dor_trans_t tr;
   } dor_preq_t;
   typedef struct packed {
      logic en;
      dor_port_t pt;
      logic dsc;
      logic aud;
      logic ssr;
   } dor_treq_t;
   typedef struct packed {
      dor_pix_t [`DOR_NPIPE-1:0] blend;
      logic [`DOR_NPIPE-1:0][`DOR_NSCL-1:0][2:0] scl;
      dor_preq_t [`DOR_NPIPE-1:0] pr;
      dor_treq_t [`DOR_NTR-1:0] tr;
      logic err;
      logic [1:0] dsi;
      logic lock;
      dor_lane_t [1:0][`DOR_NLANE-1:0] cbp;
      dor_lane_t [1:0] aux;
      dor_lane_t [`DOR_NTC-1:0][`DOR_NLANE-1:0] tcp;
      logic [`DOR_NTC-1:0] tc4;
      logic [`DOR_NTC-1:0][2:0] hp1;
      logic [`DOR_NTC-1:0][2:0] hp2;
      logic [`DOR_NTC-1:0][2:0] hpd;
      logic [`DOR_NTC-1:0] hpe;
      dor_hp_t [`DOR_NTC-1:0] hpp;
      logic [1:0] te1;
      logic [1:0] te2;
      logic [1:0] te;
      logic [`DOR_NWB-1:0] wb;
   } dor_st_t;
endpackage

// ==== verilog/dor_router.sv ====
// Display output router: blending, routing grants, lane maps, hotplug, tear
`timescale 1ns/1ns
`include "dor_params.svh"
module dor_router (
   input wire logic mclk,
   input wire logic rstn,
   input wire dor_pkg::dor_plane_t [`DOR_NPIPE-1:0][`DOR_LAYERS-1:0] plane_in,
   input wire dor_pkg::dor_pix_t [`DOR_NPIPE-1:0] bg_color,
   input wire logic [`DOR_NPIPE-1:0][`DOR_NSCL-1:0][2:0] scl_sel,
   input wire dor_pkg::dor_preq_t [`DOR_NPIPE-1:0] pipe_req,
   input wire logic pipe_join,
   input wire dor_pkg::dor_treq_t [`DOR_NTR-1:0] trans_req,
   input wire logic [`DOR_NPORT-1:0] port_mst,
   input wire dor_pkg::dor_lane_t [1:0][`DOR_NLANE-1:0] cb_in,
   input wire dor_pkg::dor_lane_t [1:0][4:0] dsi_in,
   input wire logic [1:0] cb_rev,
   input wire logic [1:0] cb_tmds,
   input wire logic [1:0] cb_dsi_strap,
   input wire dor_pkg::dor_lane_t [`DOR_NTC-1:0][`DOR_NLANE-1:0] tc_in,
   input wire dor_pkg::dor_tcm_t [`DOR_NTC-1:0] tc_mode,
   input wire logic [`DOR_NTC-1:0] tc_shared,
   input wire logic [`DOR_NTC-1:0][2:0] hp_pin,
   input wire logic te_util_pin,
   input wire logic second_tear_input_pin,
   input wire logic utility_pin_control,
   output dor_pkg::dor_pix_t [`DOR_NPIPE-1:0] blend_pix,
   output logic [`DOR_NPIPE-1:0][`DOR_NSCL-1:0][2:0] scl_tgt,
   output dor_pkg::dor_preq_t [`DOR_NPIPE-1:0] pipe_route,
   output dor_pkg::dor_treq_t [`DOR_NTR-1:0] trans_route,
   output logic route_err,
   output dor_pkg::dor_lane_t [1:0][`DOR_NLANE-1:0] cb_pin,
   output dor_pkg::dor_lane_t [1:0] cb_aux,
   output dor_pkg::dor_lane_t [`DOR_NTC-1:0][`DOR_NLANE-1:0] tc_pin,
   output logic [`DOR_NTC-1:0] tc_lanes4,
   output logic [`DOR_NTC-1:0] hp_evt,
   output dor_pkg::dor_hp_t [`DOR_NTC-1:0] hp_path,
   output logic [1:0] te_out,
   output logic [`DOR_NWB-1:0] wb_active
);
   dor_pkg::dor_st_t s_r;
   dor_pkg::dor_st_t s_nxt;

   always_comb begin
      logic [`DOR_NTR-1:0] taken;
      logic [`DOR_NPORT-1:0] used;
      logic [`DOR_NPORT-1:0] excl;
      logic ok;
      logic share_ok;
      logic keep;
      logic [2:0] rise;
      logic [1:0] idx;
      dor_pkg::dor_trans_t tr;
      dor_pkg::dor_port_t pt;
      dor_pkg::dor_pix_t px;
      taken = '0;
      used = '0;
      excl = '0;
      ok = 1'b0;
      share_ok = 1'b0;
      keep = 1'b0;
      rise = '0;
      idx = '0;
      tr = dor_pkg::TR_A;
      pt = dor_pkg::PT_NONE;
      px = '0;
      s_nxt = s_r;
      s_nxt.err = 1'b0;
      // Later layers overwrite earlier: index 7 is the cursor on top
      for (int p = 0; p < `DOR_NPIPE; p++) begin
         px = bg_color[p];
         for (int l = 0; l < `DOR_LAYERS; l++) begin
            if (plane_in[p][l].vis) begin
               px = plane_in[p][l].pix;
            end
         end
         s_nxt.blend[p] = px;
      end
      s_nxt.scl = scl_sel;
      // Pipe grants: lower pipe wins a contested transcoder
      for (int p = 0; p < `DOR_NPIPE; p++) begin
         tr = pipe_req[p].tr;
         ok = pipe_req[p].en &&
            (tr == dor_pkg::dor_trans_t'(3'(p)) || tr >= dor_pkg::TR_EDP);
         if (ok && taken[tr]) begin
            ok = pipe_join && tr != dor_pkg::TR_A && tr < dor_pkg::TR_WD0;
         end
         s_nxt.pr[p] = '0;
         if (ok) begin
            s_nxt.pr[p] = pipe_req[p];
            taken[tr] = 1'b1;
         end else if (pipe_req[p].en) begin
            s_nxt.err = 1'b1;
         end
      end
      // Transcoder grants need a feeding pipe and a reachable port
      for (int t = 0; t < `DOR_NTR; t++) begin
         pt = trans_req[t].pt;
         case (t)
            0, 1, 2: ok = pt >= dor_pkg::PT_B && pt <= dor_pkg::PT_F &&
               !(pt == dor_pkg::PT_B && s_r.dsi[1]);
            3: ok = pt == dor_pkg::PT_A && !s_r.dsi[0];
            4: ok = pt == dor_pkg::PT_A && s_r.dsi[0];
            5: ok = pt == dor_pkg::PT_B && s_r.dsi[1];
            default: ok = pt == dor_pkg::PT_MEM;
         endcase
         ok = ok && trans_req[t].en && taken[t] && s_r.lock;
         if (ok && pt <= dor_pkg::PT_F) begin
            share_ok = t < 3 && port_mst[pt] && pt != dor_pkg::PT_A;
            if (used[pt] && (excl[pt] || !share_ok)) begin
               ok = 1'b0;
            end else begin
               used[pt] = 1'b1;
               excl[pt] = excl[pt] | !share_ok;
            end
         end
         s_nxt.tr[t] = '0;
         if (ok) begin
            s_nxt.tr[t] = trans_req[t];
            s_nxt.tr[t].dsc = trans_req[t].dsc && t != 0 && t < 6;
            s_nxt.tr[t].aud = trans_req[t].aud && t < 3;
            s_nxt.tr[t].ssr = trans_req[t].ssr && t == 3;
         end else if (trans_req[t].en) begin
            s_nxt.err = 1'b1;
         end
      end
      for (int w = 0; w < `DOR_NWB; w++) begin
         s_nxt.wb[w] = s_nxt.tr[6 + w].en;
      end
      // Strap caught once after reset; later changes are ignored
      if (!s_r.lock) begin
         s_nxt.dsi = cb_dsi_strap;
         s_nxt.lock = 1'b1;
      end
      for (int c = 0; c < 2; c++) begin
         s_nxt.aux[c] = '0;
         if (!s_r.lock) begin
            s_nxt.cbp[c] = '0;
         end else if (s_r.dsi[c]) begin
            s_nxt.cbp[c][3] = dsi_in[c][3];
            s_nxt.cbp[c][2] = dsi_in[c][4];
            s_nxt.cbp[c][1] = dsi_in[c][2];
            s_nxt.cbp[c][0] = dsi_in[c][1];
            s_nxt.aux[c] = dsi_in[c][0];
         end else begin
            for (int k = 0; k < `DOR_NLANE; k++) begin
               // TMDS order on the input is clock, data0, data1, data2
               if (cb_tmds[c] ^ cb_rev[c]) begin
                  idx = 2'(3 - k);
               end else begin
                  idx = 2'(k);
               end
               s_nxt.cbp[c][k] = cb_in[c][idx];
            end
         end
      end
      // Type C lanes are never reordered here; the lane mux does it
      for (int i = 0; i < `DOR_NTC; i++) begin
         s_nxt.tc4[i] = (tc_mode[i] == dor_pkg::TCM_ALT && !tc_shared[i]) ||
            tc_mode[i] == dor_pkg::TCM_LEG;
         for (int k = 0; k < `DOR_NLANE; k++) begin
            keep = tc_mode[i] == dor_pkg::TCM_LEG ||
               (tc_mode[i] == dor_pkg::TCM_ALT && (s_nxt.tc4[i] || k < `DOR_SHR_LANES));
            s_nxt.tcp[i][k] = keep ? tc_in[i][k] : '0;
         end
      end
      // Third stage keeps the last synced level, so one rise gives one pulse
      s_nxt.hp1 = hp_pin;
      s_nxt.hp2 = s_r.hp1;
      s_nxt.hpd = s_r.hp2;
      for (int i = 0; i < `DOR_NTC; i++) begin
         rise = s_r.hp2[i] & ~s_r.hpd[i];
         s_nxt.hpe[i] = |rise;
         if (rise[0]) begin
            s_nxt.hpp[i] = dor_pkg::HP_LEG;
         end else if (rise[1]) begin
            s_nxt.hpp[i] = dor_pkg::HP_TUN;
         end else if (rise[2]) begin
            s_nxt.hpp[i] = dor_pkg::HP_ALT;
         end
      end
      // Tear pins are synced like hotplug; a missing grant masks stray pulses
      s_nxt.te1 = {second_tear_input_pin, te_util_pin};
      s_nxt.te2 = s_r.te1;
      s_nxt.te[0] = s_r.te2[0] & utility_pin_control & s_r.tr[4].en;
      s_nxt.te[1] = s_r.te2[1] & s_r.tr[5].en;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign blend_pix = s_r.blend;
   assign scl_tgt = s_r.scl;
   assign pipe_route = s_r.pr;
   assign trans_route = s_r.tr;
   assign route_err = s_r.err;
   assign cb_pin = s_r.cbp;
   assign cb_aux = s_r.aux;
   assign tc_pin = s_r.tcp;
   assign tc_lanes4 = s_r.tc4;
   assign hp_evt = s_r.hpe;
   assign hp_path = s_r.hpp;
   assign te_out = s_r.te;
   assign wb_active = s_r.wb;

   default clocking cb_main @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_cursor_on_top: assert property (
      plane_in[0][7].vis |=> blend_pix[0] == $past(plane_in[0][7].pix))
      else $error("cursor not on top");
   a_bg_shows: assert property (
      plane_in[1] == '0 |=> blend_pix[1] == $past(bg_color[1]))
      else $error("background missing");
   a_pipe_own: assert property (
      pipe_route[1].en |-> pipe_route[1].tr != dor_pkg::TR_A &&
         pipe_route[1].tr != dor_pkg::TR_C)
      else $error("pipe on foreign transcoder");
   a_dsi1_port: assert property (
      trans_route[5].en |-> trans_route[5].pt == dor_pkg::PT_B && s_r.dsi[1])
      else $error("DSI1 off port B");
   a_wb_memory: assert property (
      trans_route[6].en |-> trans_route[6].pt == dor_pkg::PT_MEM && wb_active[0])
      else $error("writeback off memory");
   a_dsc_grant: assert property (
      !trans_route[0].dsc && !trans_route[7].dsc)
      else $error("compression on barred transcoder");
   a_edp_only: assert property (
      !trans_route[1].ssr && !trans_route[3].aud)
      else $error("self refresh or audio misplaced");
   a_port_a_sst: assert property (
      trans_route[3].en && trans_route[3].pt == dor_pkg::PT_A |->
         !trans_route[4].en && !(trans_route[0].en && trans_route[0].pt == dor_pkg::PT_A))
      else $error("port A shared");
   a_combo_rev: assert property (
      s_r.lock && !s_r.dsi[0] && cb_rev[0] && !cb_tmds[0] |=>
         cb_pin[0][0] == $past(cb_in[0][3]) && cb_pin[0][3] == $past(cb_in[0][0]))
      else $error("reversal map wrong");
   a_dsi_map: assert property (
      s_r.lock && s_r.dsi[1] |=> cb_aux[1] == $past(dsi_in[1][0]) &&
         cb_pin[1][2] == $past(dsi_in[1][4]))
      else $error("DSI lane map wrong");
   a_mode_static: assert property (
      s_r.lock |=> $stable(s_r.dsi) && s_r.lock)
      else $error("combo mode changed");
   a_alt_shared: assert property (
      tc_mode[2] == dor_pkg::TCM_ALT && tc_shared[2] |=>
         !tc_lanes4[2] && tc_pin[2][3] == '0 && tc_pin[2][0] == $past(tc_in[2][0]))
      else $error("shared alt lanes wrong");
   a_hp_latency: assert property (
      $rose(hp_pin[2][2]) && hp_pin[2][1:0] == '0 ##1 hp_pin[2][1:0] == '0 |->
         ##2 hp_evt[2] && hp_path[2] == dor_pkg::HP_ALT ##1 !hp_evt[2])
      else $error("hotplug event timing");

   // Grants stay inside the legal set even under contention; scaler targets follow their selects
   a_pipe_refuse: assert property (
      pipe_req[0].en && pipe_req[0].tr == dor_pkg::TR_B |=>
         route_err && !pipe_route[0].en)
      else $error("illegal pipe route granted");
   a_err_fresh: assert property (
      pipe_req == '0 && trans_req == '0 |=> !route_err)
      else $error("error without request");
   a_tc_reach: assert property (
      trans_route[0].en |-> trans_route[0].pt >= dor_pkg::PT_B &&
         trans_route[0].pt <= dor_pkg::PT_F)
      else $error("transcoder A off ports B-F");
   a_edp_port: assert property (
      trans_route[3].en |-> trans_route[3].pt == dor_pkg::PT_A && !s_r.dsi[0])
      else $error("embedded transcoder off port A");
   a_mst_share: assert property (
      trans_route[0].en && trans_route[1].en && trans_route[0].pt == trans_route[1].pt |->
         trans_route[0].pt != dor_pkg::PT_A && $past(port_mst) != '0)
      else $error("port shared without multistream");
   a_join_gate: assert property (
      pipe_route[1].en && pipe_route[2].en && pipe_route[1].tr == pipe_route[2].tr |->
         $past(pipe_join) && pipe_route[2].tr != dor_pkg::TR_A)
      else $error("pipes joined without request");
   a_sel_fixed: assert property (
      1'b1 |=> scl_tgt == $past(scl_sel))
      else $error("scaler target lost");

   // Lane and tear paths
   a_legacy_pass: assert property (
      tc_mode[1] == dor_pkg::TCM_LEG |=> tc_lanes4[1] && tc_pin[1] == $past(tc_in[1]))
      else $error("legacy lanes not passed through");
   a_tear1_gate: assert property (
      !trans_route[5].en |=> !te_out[1])
      else $error("DSI1 tear without grant");
   a_tear0_gate: assert property (
      !(utility_pin_control && trans_route[4].en) |=> !te_out[0])
      else $error("DSI0 tear without utility pin");

   c_dsi_locked: cover property (s_r.lock && s_r.dsi == 2'b11);
   c_mst_share: cover property (trans_route[0].en && trans_route[1].en &&
      trans_route[0].pt == trans_route[1].pt);
   c_join: cover property (pipe_route[1].en && pipe_route[2].en &&
      pipe_route[1].tr == pipe_route[2].tr);
   c_hotplug: cover property (hp_evt[0]);
   c_tear_dsi1: cover property (te_out[1]);
endmodule
